// ### verilog/fm_ctrl_pkg.sv
/*
 Package for the FM tuner control block: register offsets, field
 positions, reset values and timing constants.
 Assumes a 25 MHz system clock and 32-bit APB data.
*/
`default_nettype none
package fm_ctrl_pkg;
   // -----------------------------------------------------------------
   // Clock and timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ = 25000000;
   localparam int LOCK_MIN_US = 2000;
   localparam int LOCK_MAX_US = 10000;
   localparam int STARTUP_US = 900;
   localparam int IFC_SHORT_US = 2000;
   localparam int IFC_LONG_US = 15600;
   localparam int LOCK_MIN_CYC = (LOCK_MIN_US * (CLK_HZ / 1000000));
   localparam int LOCK_MAX_CYC = (LOCK_MAX_US * (CLK_HZ / 1000000));
   localparam int STARTUP_CYC = (STARTUP_US * (CLK_HZ / 1000000));
   // Reference edges per IF count window (32.768 kHz reference)
   localparam int REF_HZ = 32768;
   localparam int IFC_SHORT_REF = (IFC_SHORT_US * REF_HZ) / 1000000;
   localparam int IFC_LONG_REF = (IFC_LONG_US * REF_HZ) / 1000000;
   // -----------------------------------------------------------------
   // Register byte offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] TUNE_WORD_OFS = 8'h00;
   localparam logic [7:0] TUNER_CTRL_OFS = 8'h04;
   localparam logic [7:0] TEST_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0c;
   localparam logic [7:0] POWER_OFS = 8'h10;
   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   // TUNE_WORD: [13:0] word, [14] search, [15] direction
   localparam int SEARCH_BIT = 14;
   localparam int DIR_BIT = 15;
   // TUNER_CTRL
   localparam int BAND_BIT = 0;
   localparam int LOCAL_BIT = 1;
   localparam int IFCP_BIT = 2;
   localparam int HYST_BIT = 3;
   localparam int SOFTDIS_BIT = 4;
   localparam int HARD_BIT = 5;
   localparam int AFM_BIT = 6;
   localparam int BLEND_BIT = 7;
   localparam int SWITCHED_BIT = 8;
   localparam int PSRC_BIT = 9;
   localparam int PVAL_BIT = 10;
   localparam int THR_LSB = 12;
   // TEST: [0] left silence, [1] right silence, [2] test select, [7:4]
   localparam int LSIL_BIT = 0;
   localparam int RSIL_BIT = 1;
   localparam int TSEL_BIT = 2;
   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [15:0] TUNE_WORD_RST = 16'h0000;
   localparam logic [15:0] TUNER_CTRL_RST = 16'h3080;
   localparam logic [7:0] TEST_RST = 8'h00;
   localparam logic [1:0] POWER_RST = 2'h0;
   localparam logic [1:0] PWR_STANDBY = 2'h0;
   localparam logic [1:0] PWR_FM_ONLY = 2'h2;
   localparam logic [1:0] PWR_ON = 2'h1;
   // IF count window (counts per 2 ms scaled)
   localparam logic [6:0] IFC_LOW = 7'h1a;
   localparam logic [6:0] IFC_HIGH = 7'h26;
   localparam logic [3:0] HYST_SMALL = 4'h1;
   localparam logic [3:0] HYST_LARGE = 4'h3;
   localparam logic [3:0] STOP_MIN = 4'h3;
   typedef enum logic [2:0] {
      TS_IDLE, TS_SETTLE, TS_COUNT, TS_STEP, TS_DONE
   } tune_state_t;
endpackage
`default_nettype wire

// ### verilog/fm_ctrl_if.sv
/*
 Interface joining the tuning sequencer to the register block.
 Assumes one clock domain, that of the register block.
*/
`default_nettype none
interface fm_ctrl_if;
   logic retrigger;
   logic [15:0] tuneWord;
   logic [15:0] tunerCtrl;
   logic fmOn;
   logic lockedIndicator;
   logic tuningDone;
   logic inRdsUpdate;
   logic [13:0] tunedWord;
   modport ctrl (output retrigger, output tuneWord, output tunerCtrl,
      output fmOn, input lockedIndicator, input tuningDone,
      input inRdsUpdate, input tunedWord);
   modport seq (input retrigger, input tuneWord, input tunerCtrl,
      input fmOn, output lockedIndicator, output tuningDone,
      output inRdsUpdate, output tunedWord);
endinterface
`default_nettype wire

// ### verilog/if_counter.sv
/*
 IF counter: counts IF edges over a window of reference-clock edges,
 giving a 7-bit result and an out-of-window flag.
 Assumes ifPulse and refEdge are one-cycle pulses already synchronised.
*/
`default_nettype none
module if_counter
   import fm_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic refEdge,
   input wire logic ifPulse,
   input wire logic shortPeriod,
   output logic [6:0] ifCount,
   output logic ifOutFlag
);
   logic [9:0] refCnt_q, refCnt_d;
   logic [15:0] acc_q, acc_d;
   logic [6:0] res_q, res_d;
   logic flag_q, flag_d;
   logic [9:0] winLen;
   logic [6:0] scaled;

   // Long window is scaled down so both periods share one 7-bit range
   assign winLen = shortPeriod ? 10'(IFC_SHORT_REF) : 10'(IFC_LONG_REF);
   assign scaled = shortPeriod ? acc_q[6:0] : 7'(acc_q >> 3);

   always_comb begin
      refCnt_d = refCnt_q;
      acc_d = acc_q;
      res_d = res_q;
      flag_d = flag_q;
      if (ifPulse) begin
         acc_d = acc_q + 16'h0001;
      end
      if (refEdge) begin
         if (refCnt_q >= winLen - 10'h001) begin
            refCnt_d = 10'h000;
            acc_d = 16'h0000;
            res_d = scaled;
            flag_d = (scaled < IFC_LOW) || (scaled > IFC_HIGH);
         end else begin
            refCnt_d = refCnt_q + 10'h001;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         refCnt_q <= 10'h000;
         acc_q <= 16'h0000;
         res_q <= 7'h00;
         flag_q <= 1'b0;
      end else begin
         refCnt_q <= refCnt_d;
         acc_q <= acc_d;
         res_q <= res_d;
         flag_q <= flag_d;
      end
   end

   assign ifCount = res_q;
   assign ifOutFlag = flag_q;
endmodule
`default_nettype wire

// ### verilog/tune_sequencer.sv
/*
 Tuning sequencer: on each retrigger while fmOn is set waits for lock, then steps a
 search or finishes a preset or RDS update.
 Assumes lockIn and levelOk are synchronous level inputs.
*/
`default_nettype none
module tune_sequencer
   import fm_ctrl_pkg::*;
#(
   parameter int LOCK_MIN = LOCK_MIN_CYC,
   parameter int LOCK_MAX = LOCK_MAX_CYC
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic lockIn,
   input wire logic levelOk,
   input wire logic ifOk,
   fm_ctrl_if.seq bus
);
   tune_state_t st_q, st_d;
   logic [17:0] tmr_q, tmr_d;
   logic [13:0] word_q, word_d;
   logic done_q, done_d;
   logic lock_q, lock_d;
   logic rds_q, rds_d;
   logic search, up, japan, shortP;
   logic [13:0] lowLim, highLim;

   assign search = bus.tuneWord[SEARCH_BIT];
   assign up = bus.tuneWord[DIR_BIT];
   assign japan = bus.tunerCtrl[BAND_BIT];
   assign shortP = bus.tunerCtrl[IFCP_BIT];
   // Band edge words, high-side injection, 32.768 kHz reference
   assign lowLim = japan ? 14'd9306 : 14'd10708;
   assign highLim = japan ? 14'd11014 : 14'd13211;

   always_comb begin
      st_d = st_q;
      tmr_d = tmr_q;
      word_d = word_q;
      done_d = done_q;
      lock_d = lock_q;
      rds_d = rds_q;
      if (bus.retrigger && bus.fmOn) begin
         st_d = TS_SETTLE;
         tmr_d = 18'h00000;
         word_d = bus.tuneWord[13:0];
         done_d = 1'b0;
         lock_d = 1'b0;
         rds_d = !search && shortP;
      end else begin
         unique case (st_q)
            TS_IDLE: begin
            end
            TS_SETTLE: begin
               tmr_d = tmr_q + 18'h00001;
               if ((tmr_q >= 18'(LOCK_MIN - 1) && lockIn) ||
                   tmr_q >= 18'(LOCK_MAX - 1)) begin
                  lock_d = lockIn;
                  st_d = TS_COUNT;
               end
            end
            TS_COUNT: begin
               if (!search) begin
                  st_d = TS_DONE;
               end else if (levelOk && ifOk) begin
                  st_d = TS_DONE;
               end else begin
                  st_d = TS_STEP;
               end
            end
            TS_STEP: begin
               tmr_d = 18'h00000;
               st_d = TS_SETTLE;
               if (up && word_q < highLim) begin
                  word_d = word_q + 14'd12;
               end else if (!up && word_q > lowLim) begin
                  word_d = word_q - 14'd12;
               end else begin
                  st_d = TS_DONE;
               end
            end
            TS_DONE: begin
               done_d = 1'b1;
               rds_d = 1'b0;
               st_d = TS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= TS_IDLE;
         tmr_q <= 18'h00000;
         word_q <= 14'h0000;
         done_q <= 1'b0;
         lock_q <= 1'b0;
         rds_q <= 1'b0;
      end else begin
         st_q <= st_d;
         tmr_q <= tmr_d;
         word_q <= word_d;
         done_q <= done_d;
         lock_q <= lock_d;
         rds_q <= rds_d;
      end
   end

   assign bus.lockedIndicator = lock_q;
   assign bus.tuningDone = done_q;
   assign bus.inRdsUpdate = rds_q;
   assign bus.tunedWord = word_q;
endmodule
`default_nettype wire

// ### verilog/fm_tuner_control_logic.sv
/*
 Top of the FM tuner digital control layer: APB register slave,
 reference sampling, IF counter, level flag, mute, blend, port and
 power states.
 Assumes an APB master on clk, and pin inputs asynchronous to clk.
*/
`default_nettype none
module fm_tuner_control_logic
   import fm_ctrl_pkg::*;
#(
   parameter int LOCK_MIN = LOCK_MIN_CYC,
   parameter int LOCK_MAX = LOCK_MAX_CYC,
   parameter int STARTUP = STARTUP_CYC
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ref_clock_input,
   input wire logic ifPulseIn,
   input wire logic pllLockIn,
   input wire logic [3:0] levelIn,
   input wire logic stereoPilotIn,
   output logic left_audio_out,
   output logic left_audio_out_oe,
   output logic right_audio_out,
   output logic right_audio_out_oe,
   output logic audioBlock,
   output logic softAttenuationOn,
   output logic lowGain,
   output logic forceMono,
   output logic blendEnable,
   output logic blendSwitched,
   output logic portOut,
   output logic fmPowerOn,
   output logic rdsPowerOn,
   output logic rdsDataEnable,
   output logic [7:0] rdsDefaultsOut
);
   import fm_ctrl_pkg::*;

   fm_ctrl_if link ();

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [7:0] syncA_q, syncB_q;
   logic refPrev_q, ifPrev_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         syncA_q <= 8'h00;
         syncB_q <= 8'h00;
         refPrev_q <= 1'b0;
         ifPrev_q <= 1'b0;
      end else begin
         syncA_q <= {stereoPilotIn, levelIn, pllLockIn, ifPulseIn,
            ref_clock_input};
         syncB_q <= syncA_q;
         refPrev_q <= syncB_q[0];
         ifPrev_q <= syncB_q[1];
      end
   end
   logic refEdge, ifEdge, lockS, pilotS;
   logic [3:0] levelS;
   assign refEdge = syncB_q[0] && !refPrev_q;
   assign ifEdge = syncB_q[1] && !ifPrev_q;
   assign lockS = syncB_q[2];
   assign levelS = syncB_q[6:3];
   assign pilotS = syncB_q[7];

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [15:0] tune_q, tune_d;
   logic [15:0] ctrl_q, ctrl_d;
   logic [7:0] test_q, test_d;
   logic [1:0] pwr_q, pwr_d;
   logic retrig_q, retrig_d;
   logic [31:0] rdata_q, rdata_d;
   logic wrAcc, rdAcc, mapped;
   logic [6:0] ifCount;
   logic ifOutFlag;
   logic levelLow_q, levelLow_d;
   logic [19:0] startCnt_q, startCnt_d;
   logic rdsReady_q, rdsReady_d;
   logic [7:0] rdsBytes_q, rdsBytes_d;
   logic [2:0] rdsFlags_q, rdsFlags_d;

   assign wrAcc = psel && penable && pwrite;
   assign rdAcc = psel && !penable && !pwrite;
   assign mapped = (paddr == TUNE_WORD_OFS) || (paddr == TUNER_CTRL_OFS)
      || (paddr == TEST_OFS) || (paddr == STATUS_OFS)
      || (paddr == POWER_OFS);

   always_comb begin
      tune_d = tune_q;
      ctrl_d = ctrl_q;
      test_d = test_q;
      pwr_d = pwr_q;
      retrig_d = 1'b0;
      rdata_d = rdata_q;
      if (wrAcc) begin
         unique case (paddr)
            TUNE_WORD_OFS: begin
               tune_d = pwdata[15:0];
               retrig_d = 1'b1;
            end
            TUNER_CTRL_OFS: begin
               ctrl_d = pwdata[15:0];
               retrig_d = 1'b1;
            end
            TEST_OFS: begin
               test_d = pwdata[7:0];
               retrig_d = 1'b1;
            end
            POWER_OFS: begin
               pwr_d = pwdata[1:0];
            end
            default: begin
            end
         endcase
      end
      if (rdAcc) begin
         unique case (paddr)
            TUNE_WORD_OFS: rdata_d = {16'h0000, tune_q};
            TUNER_CTRL_OFS: rdata_d = {16'h0000, ctrl_q};
            TEST_OFS: rdata_d = {24'h000000, test_q};
            STATUS_OFS: rdata_d = {rdsFlags_q, link.tunedWord, levelS,
               ifCount, ifOutFlag, levelLow_q, link.tuningDone,
               link.lockedIndicator};
            POWER_OFS: rdata_d = {29'h0, rdsReady_q, pwr_q};
            default: rdata_d = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tune_q <= TUNE_WORD_RST;
         ctrl_q <= TUNER_CTRL_RST;
         test_q <= TEST_RST;
         pwr_q <= POWER_RST;
         retrig_q <= 1'b0;
         rdata_q <= 32'h00000000;
      end else begin
         tune_q <= tune_d;
         ctrl_q <= ctrl_d;
         test_q <= test_d;
         pwr_q <= pwr_d;
         retrig_q <= retrig_d;
         rdata_q <= rdata_d;
      end
   end

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = rdata_q;

   // ---------------------------------------------------------------
   // Tuning sequencer and IF counter
   // ---------------------------------------------------------------
   logic shortPeriod;
   assign link.retrigger = retrig_q;
   assign link.tuneWord = tune_q;
   assign link.tunerCtrl = ctrl_q;
   assign link.fmOn = fmPowerOn;
   // Short window only until tuning completes
   assign shortPeriod = ctrl_q[IFCP_BIT] && !link.tuningDone;

   tune_sequencer #(
      .LOCK_MIN(LOCK_MIN),
      .LOCK_MAX(LOCK_MAX)
   ) u_seq (
      .clk(clk),
      .rstn(rstn),
      .lockIn(lockS),
      .levelOk(!levelLow_q),
      .ifOk(!ifOutFlag),
      .bus(link)
   );

   if_counter u_ifc (
      .clk(clk),
      .rstn(rstn),
      .refEdge(refEdge),
      .ifPulse(ifEdge),
      .shortPeriod(shortPeriod),
      .ifCount(ifCount),
      .ifOutFlag(ifOutFlag)
   );

   // ---------------------------------------------------------------
   // Level flag with hysteresis
   // ---------------------------------------------------------------
   logic [3:0] thr, hyst, effThr;
   assign thr = (ctrl_q[THR_LSB +: 4] < STOP_MIN) ? STOP_MIN :
      ctrl_q[THR_LSB +: 4];
   assign hyst = ctrl_q[HYST_BIT] ? HYST_LARGE : HYST_SMALL;
   // Once tuned the hysteresis lowers the limit, at minimum down to 0
   assign effThr = !link.tuningDone ? thr :
      (thr > hyst ? thr - hyst : 4'h0);
   always_comb begin
      levelLow_d = levelS < effThr;
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         levelLow_q <= 1'b0;
      end else begin
         levelLow_q <= levelLow_d;
      end
   end

   // ---------------------------------------------------------------
   // Power states and start-up
   // ---------------------------------------------------------------
   always_comb begin
      startCnt_d = startCnt_q;
      rdsReady_d = rdsReady_q;
      rdsBytes_d = rdsBytes_q;
      rdsFlags_d = rdsFlags_q;
      if (pwr_q != PWR_ON) begin
         startCnt_d = 20'h00000;
         rdsReady_d = 1'b0;
      end else if (!rdsReady_q) begin
         if (startCnt_q >= 20'(STARTUP - 1)) begin
            rdsReady_d = 1'b1;
            rdsBytes_d = 8'h00;
            rdsFlags_d = 3'h0;
         end else begin
            startCnt_d = startCnt_q + 20'h00001;
         end
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         startCnt_q <= 20'h00000;
         rdsReady_q <= 1'b0;
      end else begin
         startCnt_q <= startCnt_d;
         rdsReady_q <= rdsReady_d;
      end
   end
   // RDS state is not cleared by reset, only by power-up
   always_ff @(posedge clk) begin
      rdsBytes_q <= rdsBytes_d;
      rdsFlags_q <= rdsFlags_d;
   end

   assign fmPowerOn = (pwr_q == PWR_ON) || (pwr_q == PWR_FM_ONLY);
   assign rdsPowerOn = (pwr_q == PWR_ON) && rdsReady_q;
   assign rdsDefaultsOut = rdsBytes_q;

   // ---------------------------------------------------------------
   // Audio, blend and port
   // ---------------------------------------------------------------
   logic standby;
   assign standby = !fmPowerOn;
   assign left_audio_out = 1'b0;
   assign right_audio_out = 1'b0;
   assign left_audio_out_oe = !(standby || ctrl_q[HARD_BIT] ||
      test_q[LSIL_BIT]);
   assign right_audio_out_oe = !(standby || ctrl_q[HARD_BIT] ||
      test_q[RSIL_BIT]);
   assign audioBlock = ctrl_q[AFM_BIT] || link.inRdsUpdate;
   assign softAttenuationOn = !ctrl_q[SOFTDIS_BIT];
   assign lowGain = ctrl_q[LOCAL_BIT];
   assign forceMono = test_q[LSIL_BIT] || test_q[RSIL_BIT];
   assign blendEnable = ctrl_q[BLEND_BIT] && pilotS;
   assign blendSwitched = ctrl_q[SWITCHED_BIT];
   assign rdsDataEnable = rdsPowerOn && ctrl_q[AFM_BIT];
   // Port stays live in every power state
   assign portOut = test_q[TSEL_BIT] ? link.lockedIndicator :
      (ctrl_q[PSRC_BIT] ? link.tuningDone : ctrl_q[PVAL_BIT]);
endmodule
`default_nettype wire

// ### verification/fm_ctrl_checker.sv
/*
 Checker for the FM tuner control top: APB answer and control levels.
 Assumes it is bound to fm_tuner_control_logic.
*/
`default_nettype none
module fm_ctrl_checker
   import fm_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic left_audio_out_oe,
   input wire logic right_audio_out_oe,
   input wire logic audioBlock,
   input wire logic softAttenuationOn,
   input wire logic lowGain,
   input wire logic blendEnable,
   input wire logic blendSwitched,
   input wire logic fmPowerOn,
   input wire logic rdsDataEnable
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   wire logic acc = psel && penable;
   wire logic wc = acc && pwrite && paddr == TUNER_CTRL_OFS;
   wire logic mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
   // ------------------------------------------------------------
   // Bus answer and control levels
   // ------------------------------------------------------------
   a_ready_now: assert property (acc |-> pready)
      else $error("pready low in access phase");
   a_unmapped_err: assert property (acc && !mapped |-> pslverr)
      else $error("unmapped access without pslverr");
   a_standby_quiet: assert property (
      !fmPowerOn |-> !left_audio_out_oe && !right_audio_out_oe)
      else $error("audio driven in standby");
   a_local_gain: assert property (
      wc |-> ##2 lowGain == $past(pwdata[LOCAL_BIT], 2))
      else $error("gain cut does not follow write");
   a_blend_on: assert property (
      wc |-> ##2 blendEnable == $past(pwdata[BLEND_BIT], 2))
      else $error("blend enable does not follow write");
   a_blend_switch: assert property (
      wc |-> ##2 blendSwitched == $past(pwdata[SWITCHED_BIT], 2))
      else $error("switched blend does not follow write");
   a_soft_off: assert property (
      wc && pwdata[SOFTDIS_BIT] |-> ##2 !softAttenuationOn)
      else $error("soft attenuation still on");
   a_afm_block: assert property (
      wc && pwdata[AFM_BIT] |-> ##2 audioBlock)
      else $error("audio not blocked");
   a_rds_stop: assert property (
      wc && !pwdata[AFM_BIT] |-> ##2 !rdsDataEnable)
      else $error("data delivery not stopped");
   a_hard_silence: assert property (
      wc && pwdata[HARD_BIT] |-> ##2 !left_audio_out_oe[*2])
      else $error("audio driven under hard silence");
endmodule
bind fm_tuner_control_logic fm_ctrl_checker u_chk (.clk, .rstn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
   .left_audio_out_oe, .right_audio_out_oe, .audioBlock,
   .softAttenuationOn, .lowGain, .blendEnable, .blendSwitched,
   .fmPowerOn, .rdsDataEnable);
`default_nettype wire

// ### verification/front_model.sv
/*
 Model of the analog front end: reference clock, IF edges, lock, level.
 Assumes retune pulses high whenever the host asks for a new frequency.
*/
`default_nettype none
module front_model #(
   parameter int LOCK_NS = 1200
)
(
   input wire logic retune,
   output logic ref_clock_input,
   output logic ifPulseIn,
   output logic pllLockIn,
   output logic [3:0] levelIn,
   output logic stereoPilotIn
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      ref_clock_input = 1'b0;
      #37;
      forever #160 ref_clock_input = ~ref_clock_input;
   end
   initial begin
      ifPulseIn = 1'b0;
      forever #2222 ifPulseIn = ~ifPulseIn;
   end
   initial begin
      levelIn = 4'h9;
      stereoPilotIn = 1'b1;
      pllLockIn = 1'b0;
   end
   // Lock is lost on each retune and regained after the loop settles
   always @(posedge retune) begin
      pllLockIn = 1'b0;
      #LOCK_NS pllLockIn = 1'b1;
   end
endmodule
`default_nettype wire

// ### verification/testbench.sv
/*
 Self-checking bench for the FM tuner control top over APB.
 Assumes shortened lock and start-up counts set below.
*/
`default_nettype none
module testbench;
   import fm_ctrl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // Tune word for 100.1 MHz, high-side, truncated
   localparam logic [31:0] TW = 32'h0000_2fd6;
   logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, retune = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, v, seed = 32'd9086;
   logic [31:0] expQ[$];
   logic pready, pslverr, ref_clock_input, ifPulseIn, pllLockIn;
   logic stereoPilotIn, left_audio_out, right_audio_out, audioBlock;
   logic left_audio_out_oe, right_audio_out_oe, softAttenuationOn;
   logic lowGain, forceMono, blendEnable, blendSwitched, portOut;
   logic fmPowerOn, rdsPowerOn, rdsDataEnable;
   logic [3:0] levelIn;
   logic [7:0] rdsDefaultsOut;
   int n_fail = 0, n_checks = 0;
   fm_tuner_control_logic #(.LOCK_MIN(20), .LOCK_MAX(100), .STARTUP(30))
   u_dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .ref_clock_input, .ifPulseIn,
      .pllLockIn, .levelIn, .stereoPilotIn, .left_audio_out,
      .left_audio_out_oe, .right_audio_out, .right_audio_out_oe,
      .audioBlock, .softAttenuationOn, .lowGain, .forceMono,
      .blendEnable, .blendSwitched, .portOut, .fmPowerOn, .rdsPowerOn,
      .rdsDataEnable, .rdsDefaultsOut);
   front_model u_front (.retune, .ref_clock_input, .ifPulseIn,
      .pllLockIn, .levelIn, .stereoPilotIn);
   initial begin
      forever #20 clk = ~clk;
   end
   // ------------------------------------------------------------
   // Bus tasks and comparisons
   // ------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic cmpWord(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cmpBit(input logic g, input logic e);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expQ.push_back(e);
      xfer(1'b0, a, 32'h0);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic waitPort();
      repeat (2) @(posedge clk);
      for (int i = 0; i < 400 && portOut !== 1'b1; i++) @(posedge clk);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Read data stands in the access phase and is taken at its edge
   always @(posedge clk) begin
      if (psel && penable && !pwrite && pready === 1'b1) begin
         cmpWord(prdata, expQ.pop_front());
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      tally_and_finish();
   end
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      rd(TUNER_CTRL_OFS, {16'h0, TUNER_CTRL_RST});
      rd(POWER_OFS, 32'h0);
      rd(8'h20, 32'h0);
      settle(1);
      cmpBit(left_audio_out_oe, 1'b0);
      xfer(1'b1, POWER_OFS, {30'h0, PWR_FM_ONLY});
      settle(40);
      cmpBit(fmPowerOn, 1'b1);
      cmpBit(rdsPowerOn, 1'b0);
      xfer(1'b1, POWER_OFS, {30'h0, PWR_ON});
      settle(40);
      cmpBit(rdsPowerOn, 1'b1);
      rd(POWER_OFS, 32'h5);
      cmpWord({24'h0, rdsDefaultsOut}, 32'h0);
      repeat (8) begin
         v = xs() & 32'h0000_05ff;
         xfer(1'b1, TUNER_CTRL_OFS, v);
         settle(3);
         cmpBit(lowGain, v[LOCAL_BIT]);
         cmpBit(blendSwitched, v[SWITCHED_BIT]);
         cmpBit(portOut, v[PVAL_BIT]);
         cmpBit(left_audio_out_oe, !v[HARD_BIT]);
         cmpBit(softAttenuationOn, !v[SOFTDIS_BIT]);
         cmpBit(audioBlock, v[AFM_BIT] | v[IFCP_BIT]);
         cmpBit(blendEnable, v[BLEND_BIT]);
         cmpBit(rdsDataEnable, v[AFM_BIT]);
      end
      xfer(1'b1, TUNER_CTRL_OFS, {16'h0, TUNER_CTRL_RST} | 32'h200);
      retune <= 1'b1;
      xfer(1'b1, TUNE_WORD_OFS, TW);
      retune <= 1'b0;
      waitPort();
      cmpBit(portOut, 1'b1);
      rd(TUNE_WORD_OFS, TW);
      xfer(1'b1, TEST_OFS, 32'h1 << TSEL_BIT);
      waitPort();
      cmpBit(portOut, 1'b1);
      xfer(1'b1, TEST_OFS, 32'h1 << LSIL_BIT);
      settle(3);
      cmpBit(left_audio_out_oe, 1'b0);
      cmpBit(right_audio_out_oe, 1'b1);
      cmpBit(forceMono, 1'b1);
      xfer(1'b1, POWER_OFS, {30'h0, PWR_STANDBY});
      settle(3);
      cmpBit(right_audio_out_oe, 1'b0);
      rd(TUNE_WORD_OFS, TW);
      settle(3);
      tally_and_finish();
   end
endmodule
`default_nettype wire
